// File: hw/lsth_rhda_pkg.sv
// Package: offsets, reset values and field layouts of the two registers
package lsth_rhda_pkg;
  // Register byte offsets
  localparam logic [7:0] LS_THRESHOLD_OFFSET = 8'h44;
  localparam logic [7:0] RH_DESC_FIRST_OFFSET = 8'h48;
  // Threshold register layout
  localparam int LS_THRESHOLD_WIDTH = 12;
  localparam logic [11:0] LS_THRESHOLD_RESET = 12'h628;
  localparam int FRAME_REMAINING_WIDTH = 14;
  // Descriptor field positions
  localparam int POWER_GOOD_LSB = 24;
  localparam int NO_OC_PROT_BIT = 12;
  localparam int OC_MODE_BIT = 11;
  localparam int COMPOUND_BIT = 10;
  localparam int ALWAYS_POWERED_BIT = 9;
  localparam int SWITCH_MODE_BIT = 8;
  localparam int PORT_COUNT_LSB = 0;
  // Descriptor reset values
  localparam logic [7:0] POWER_GOOD_RESET = 8'hff;
  localparam logic NO_OC_PROT_RESET = 1'b0;
  localparam logic ALWAYS_POWERED_RESET = 1'b0;
  localparam logic SWITCH_MODE_RESET = 1'b1;
  localparam logic [7:0] PORT_COUNT_DEFAULT = 8'h02;
  localparam logic [7:0] PORT_COUNT_MAX = 8'h0f;
  // Power-good time unit in ms
  localparam int POWER_GOOD_UNIT_MS = 2;

  // Writable descriptor fields
  typedef struct packed {
    logic [7:0] power_good_wait_time;
    logic no_overcurrent_protection;
    logic overcurrent_report_mode;
    logic ports_always_powered;
    logic power_switch_mode;
  } desc_fields_type;

  // Effective root hub configuration seen by port logic
  typedef struct packed {
    logic [7:0] power_good_wait_time;
    logic oc_protection_absent;
    logic oc_per_port;
    logic ports_always_powered;
    logic per_port_power;
    logic [7:0] downstream_port_count;
  } hub_config_type;
endpackage : lsth_rhda_pkg

// File: hw/lsth_rhda_regs.sv
// Low-speed threshold and first root hub descriptor registers
//
// Functional notes
// - Threshold decides whether an 8-byte low-speed packet fits before frame end.
// - Low-speed start allowed only when frame remaining count >= 12-bit threshold.
// - Controller logic never alters the threshold; only register writes change it.
// - Bit 12 set means no overcurrent protection; clear lets bit 11 choose.
// - Overcurrent mode bit 11 resets to power switch mode value.
// - Overcurrent mode only takes effect while no-protection flag is clear.
// - Compound device bit 10 always reads zero and ignores writes.
// - Bit 9 clear means ports switched; set means always powered.
// - Bit 8 selects ganged or per-port power, only when bit 9 clear.
// - Read-only port count in bits 7:0, between 1 and 15.
`timescale 1ns/100ps
`default_nettype none
module lsth_rhda_regs #(
  parameter logic [7:0] PORT_COUNT = lsth_rhda_pkg::PORT_COUNT_DEFAULT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [3:0] reg_be_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Frame logic
  input wire logic [13:0] frame_remaining_count_in,
  input wire logic ls_request_in,
  output logic ls_start_allowed_out,
  output logic [11:0] lowspeed_threshold_field_out,
  // Root hub configuration
  output var lsth_rhda_pkg::hub_config_type hub_config_out
);

  logic [11:0] lowspeed_threshold_field_reg;
  lsth_rhda_pkg::desc_fields_type desc_reg;
  logic [31:0] desc_word;
  logic [31:0] thr_word;
  logic wr_thr;
  logic wr_desc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  assign wr_thr = reg_wr_in && hit(reg_addr_in,
    lsth_rhda_pkg::LS_THRESHOLD_OFFSET);
  assign wr_desc = reg_wr_in && hit(reg_addr_in,
    lsth_rhda_pkg::RH_DESC_FIRST_OFFSET);

  // Threshold register, written only by software
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lowspeed_threshold_field_reg <= lsth_rhda_pkg::LS_THRESHOLD_RESET;
    end else if (wr_thr) begin
      if (reg_be_in[0]) begin
        lowspeed_threshold_field_reg[7:0] <= reg_wdata_in[7:0];
      end
      if (reg_be_in[1]) begin
        lowspeed_threshold_field_reg[11:8] <= reg_wdata_in[11:8];
      end
    end
  end

  // Descriptor writable fields
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      desc_reg.power_good_wait_time <= lsth_rhda_pkg::POWER_GOOD_RESET;
      desc_reg.no_overcurrent_protection <= lsth_rhda_pkg::NO_OC_PROT_RESET;
      desc_reg.overcurrent_report_mode <=
        lsth_rhda_pkg::SWITCH_MODE_RESET;
      desc_reg.ports_always_powered <= lsth_rhda_pkg::ALWAYS_POWERED_RESET;
      desc_reg.power_switch_mode <= lsth_rhda_pkg::SWITCH_MODE_RESET;
    end else if (wr_desc) begin
      if (reg_be_in[3]) begin
        desc_reg.power_good_wait_time <=
          reg_wdata_in[lsth_rhda_pkg::POWER_GOOD_LSB +: 8];
      end
      if (reg_be_in[1]) begin
        desc_reg.no_overcurrent_protection <=
          reg_wdata_in[lsth_rhda_pkg::NO_OC_PROT_BIT];
        desc_reg.overcurrent_report_mode <=
          reg_wdata_in[lsth_rhda_pkg::OC_MODE_BIT];
        desc_reg.ports_always_powered <=
          reg_wdata_in[lsth_rhda_pkg::ALWAYS_POWERED_BIT];
        desc_reg.power_switch_mode <=
          reg_wdata_in[lsth_rhda_pkg::SWITCH_MODE_BIT];
      end
    end
  end

  // Read words; reserved and compound bits fixed at zero
  always_comb begin
    thr_word = 32'h0000_0000;
    thr_word[11:0] = lowspeed_threshold_field_reg;
    desc_word = 32'h0000_0000;
    desc_word[lsth_rhda_pkg::POWER_GOOD_LSB +: 8] =
      desc_reg.power_good_wait_time;
    desc_word[lsth_rhda_pkg::NO_OC_PROT_BIT] =
      desc_reg.no_overcurrent_protection;
    desc_word[lsth_rhda_pkg::OC_MODE_BIT] = desc_reg.overcurrent_report_mode;
    desc_word[lsth_rhda_pkg::COMPOUND_BIT] = 1'b0;
    desc_word[lsth_rhda_pkg::ALWAYS_POWERED_BIT] =
      desc_reg.ports_always_powered;
    desc_word[lsth_rhda_pkg::SWITCH_MODE_BIT] = desc_reg.power_switch_mode;
    desc_word[lsth_rhda_pkg::PORT_COUNT_LSB +: 8] = PORT_COUNT;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (!reg_rd_in) begin
        reg_rdata_out <= 32'h0000_0000;
      end else if (hit(reg_addr_in, lsth_rhda_pkg::LS_THRESHOLD_OFFSET)) begin
        reg_rdata_out <= thr_word;
      end else if (hit(reg_addr_in, lsth_rhda_pkg::RH_DESC_FIRST_OFFSET)) begin
        reg_rdata_out <= desc_word;
      end else begin
        reg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Low-speed commit decision
  assign ls_start_allowed_out = ls_request_in &&
    ({2'b00, lowspeed_threshold_field_reg} <=
     frame_remaining_count_in);
  assign lowspeed_threshold_field_out = lowspeed_threshold_field_reg;

  // Effective configuration
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hub_config_out <= '0;
    end else begin
      hub_config_out.power_good_wait_time <= desc_reg.power_good_wait_time;
      hub_config_out.oc_protection_absent <=
        desc_reg.no_overcurrent_protection;
      hub_config_out.oc_per_port <= desc_reg.overcurrent_report_mode &&
        !desc_reg.no_overcurrent_protection;
      hub_config_out.ports_always_powered <=
        desc_reg.ports_always_powered;
      hub_config_out.per_port_power <= desc_reg.power_switch_mode &&
        !desc_reg.ports_always_powered;
      hub_config_out.downstream_port_count <= PORT_COUNT;
    end
  end

  // Checks
  property p_ls_gate;
    @(posedge clk_in) disable iff (sys_rst_in)
    ls_request_in |-> (ls_start_allowed_out ==
      (frame_remaining_count_in >= {2'b00, lowspeed_threshold_field_reg}));
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("ls gate wrong");

  property p_ls_idle;
    @(posedge clk_in) disable iff (sys_rst_in)
    !ls_request_in |-> !ls_start_allowed_out;
  endproperty
  a_ls_idle: assert property (p_ls_idle) else $error("ls start no req");

  property p_thr_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
    !wr_thr |=> $stable(lowspeed_threshold_field_reg);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("thr changed");

  property p_thr_read;
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && hit(reg_addr_in, lsth_rhda_pkg::LS_THRESHOLD_OFFSET)
      |=> reg_rvalid_out && reg_rdata_out[31:12] == 20'h00000;
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("thr rsvd");

  property p_dt_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && hit(reg_addr_in, lsth_rhda_pkg::RH_DESC_FIRST_OFFSET)
      |=> !reg_rdata_out[lsth_rhda_pkg::COMPOUND_BIT];
  endproperty
  a_dt_zero: assert property (p_dt_zero) else $error("dt not zero");

  property p_ndp;
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && hit(reg_addr_in, lsth_rhda_pkg::RH_DESC_FIRST_OFFSET)
      |=> reg_rdata_out[7:0] == PORT_COUNT && reg_rdata_out[23:13] == 11'h000;
  endproperty
  a_ndp: assert property (p_ndp) else $error("port count wrong");

  property p_overcurrent_report_mode_mask;
    @(posedge clk_in) disable iff (sys_rst_in)
    desc_reg.no_overcurrent_protection |=> !hub_config_out.oc_per_port;
  endproperty
  a_overcurrent_report_mode_mask: assert property (p_overcurrent_report_mode_mask) else $error("overcurrent_report_mode used");

  property p_psm_mask;
    @(posedge clk_in) disable iff (sys_rst_in)
    desc_reg.ports_always_powered |=> !hub_config_out.per_port_power;
  endproperty
  a_psm_mask: assert property (p_psm_mask) else $error("psm used");

  property p_overcurrent_report_mode_reset;
    @(posedge clk_in)
    $fell(sys_rst_in) |->
      desc_reg.overcurrent_report_mode == desc_reg.power_switch_mode;
  endproperty
  a_overcurrent_report_mode_reset: assert property (p_overcurrent_report_mode_reset) else $error("overcurrent_report_mode rst");

  property p_port_range;
    @(posedge clk_in) disable iff (sys_rst_in)
    PORT_COUNT >= 8'h01 && PORT_COUNT <= lsth_rhda_pkg::PORT_COUNT_MAX;
  endproperty
  a_port_range: assert property (p_port_range) else $error("bad ports");

  c_ls_go: cover property (@(posedge clk_in) ls_start_allowed_out);
  c_ls_block: cover property (@(posedge clk_in)
    ls_request_in && !ls_start_allowed_out);
  c_thr_wr: cover property (@(posedge clk_in) wr_thr ##1 reg_rd_in);
  c_desc_wr: cover property (@(posedge clk_in) wr_desc);

endmodule : lsth_rhda_regs
`default_nettype wire

// File: testbench/host_driver_model.sv
// Host driver model on the register strobe port
`timescale 1ns/100ps
`default_nettype none
module host_driver_model (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [3:0] reg_be_out,
  output logic [31:0] reg_wdata_out,
  input wire logic [31:0] reg_rdata_in,
  input wire logic reg_rvalid_in
);
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_be_out = 4'h0;
    reg_wdata_out = 32'h00000000;
  end
  // Threshold from packet time plus set-up overhead
  function automatic logic [11:0] threshold_for(input logic [11:0] pkt,
                                                input logic [11:0] setup);
    return pkt + setup;
  endfunction : threshold_for
  // Wait after port power-on, in ms
  function automatic int power_good_ms(input logic [7:0] pg);
    return pg * lsth_rhda_pkg::POWER_GOOD_UNIT_MS;
  endfunction : power_good_ms
  // Reserved bits written with their reset value
  function automatic logic [31:0] keep_reserved(input logic [7:0] addr,
                                                input logic [31:0] data);
    return data & ((addr == 8'h44) ? 32'h00000fff : 32'hff001b00);
  endfunction : keep_reserved
  task automatic write_reg(input logic [7:0] addr, input logic [3:0] be,
                           input logic [31:0] data);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_be_out = be;
    reg_wdata_out = data;
    reg_wr_out = 1'b1;
    @(negedge clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~data;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data,
                          output logic ok);
    ok = 1'b0;
    data = 32'h00000000;
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_rd_out = 1'b1;
    @(negedge clk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~addr;
    for (int i = 0; i < 4; i++) begin
      if (!ok && reg_rvalid_in === 1'b1) begin
        data = reg_rdata_in;
        ok = 1'b1;
      end else if (!ok) begin
        @(negedge clk_in);
      end
    end
  endtask : read_reg
endmodule : host_driver_model
`default_nettype wire

// File: testbench/ohci_lowspeed_threshold_roothub_desc_a_tb_top.sv
// Testbench for the threshold and root hub descriptor registers
`timescale 1ns/100ps
`default_nettype none
module ohci_lowspeed_threshold_roothub_desc_a_tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, ls_allowed;
  logic [7:0] reg_addr;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata, reg_rdata;
  logic [13:0] frame_count = 14'h0000;
  logic ls_request = 1'b0;
  logic [11:0] threshold;
  lsth_rhda_pkg::hub_config_type hub_cfg;
  int n_mismatch = 0;
  int checks = 0;
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  lsth_rhda_regs i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
    .reg_be_in(reg_be), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
    .frame_remaining_count_in(frame_count), .ls_request_in(ls_request),
    .ls_start_allowed_out(ls_allowed),
    .lowspeed_threshold_field_out(threshold), .hub_config_out(hub_cfg));
  host_driver_model i_host (.clk_in(clk_in), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_addr_out(reg_addr), .reg_be_out(reg_be),
    .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata),
    .reg_rvalid_in(reg_rvalid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic rd_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] data;
    logic ok;
    i_host.read_reg(addr, data, ok);
    if (!ok) begin
      n_mismatch++;
      finish_test();
    end
    check(data, exp);
  endtask : rd_check
  task automatic gate(input logic req, input logic [13:0] cnt,
                      input logic exp);
    @(negedge clk_in);
    ls_request = req;
    frame_count = cnt;
    #1;
    check({31'h0, ls_allowed}, {31'h0, exp});
  endtask : gate
  task automatic do_reset();
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
  endtask : do_reset
  task automatic test_reset_values();
    rd_check(8'h44, 32'h00000628);
    rd_check(8'h48, 32'hff000902);
    check({12'h0, hub_cfg}, {12'h0, 8'hff, 4'b0101, 8'h02});
  endtask : test_reset_values
  task automatic test_gate();
    gate(1'b1, 14'h0628, 1'b1);
    gate(1'b1, 14'h0627, 1'b0);
    gate(1'b0, 14'h3fff, 1'b0);
    i_host.write_reg(8'h44, 4'h3,
      {20'h0, i_host.threshold_for(12'h700, 12'h0a0)});
    gate(1'b1, 14'h07a0, 1'b1);
    gate(1'b1, 14'h079f, 1'b0);
    i_host.write_reg(8'h44, 4'hf, 32'hffffffff);
    rd_check(8'h44, 32'h00000fff);
    gate(1'b1, 14'h0ffe, 1'b0);
    gate(1'b1, 14'h0fff, 1'b1);
    for (int i = 0; i < 8; i++) begin
      gate(1'b1, 14'(i), 1'b0);
    end
    check({20'h0, threshold}, 32'h00000fff);
  endtask : test_gate
  task automatic test_descriptor();
    i_host.write_reg(8'h48, 4'hf, 32'hffffffff);
    rd_check(8'h48, 32'hff001b02);
    check({12'h0, hub_cfg}, {12'h0, 8'hff, 4'b1010, 8'h02});
    i_host.write_reg(8'h48, 4'hf, i_host.keep_reserved(8'h48, 32'h320009ff));
    rd_check(8'h48, 32'h32000902);
    check({12'h0, hub_cfg}, {12'h0, 8'h32, 4'b0101, 8'h02});
    check(i_host.power_good_ms(hub_cfg.power_good_wait_time),
      32'h00000064);
    i_host.write_reg(8'h48, 4'h8, 32'h00001a00);
    rd_check(8'h48, 32'h00000902);
  endtask : test_descriptor
  task automatic test_unmapped();
    i_host.write_reg(8'h4c, 4'hf, 32'hffffffff);
    rd_check(8'h4c, 32'h00000000);
    rd_check(8'h44, 32'h00000fff);
  endtask : test_unmapped
  initial begin
    do_reset();
    test_reset_values();
    test_gate();
    test_descriptor();
    test_unmapped();
    do_reset();
    rd_check(8'h44, 32'h00000628);
    finish_test();
  end
endmodule : ohci_lowspeed_threshold_roothub_desc_a_tb_top
`default_nettype wire
